// ==== verilog/monitor_regs.svh ====
// Purpose: Offsets, field positions, reset values, codes and timing of the monitor core.
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus.
// Notes: Included by its bare name.
// Behaviour
// - Direct command selected by 7-bit address
// - Command triggers action, accepts data or returns data
// - Subcommands reached via command space, block data
// - Power-up copies stored settings to registers
// - Registers kept in normal, sleep, retention
// - Shutdown clears; power-up restores defaults or stored
// - Restricted: read most, few writes, no memory
// - Intermediate adds subcommands and memory read/write
// - Unrestricted changes everything, programs stored settings
// - Rewrite state only unrestricted; halts, restarts after
// - Each level raise needs its own keys
// - Signature over instruction and data ROM
// - Static settings signature compared, mismatch flagged
// - Scratchpad 32 bytes, read always, write unrestricted
// - Cell result corrected, 16-bit millivolts
// - Raw 24-bit result returned as 32-bit
// - Loop: five cells, two rotating slots, auxiliaries
// - Loop length 7 to 10 slots
// - Slot lasts 3 ms or 1.5 ms
// - Slow speed appends idle slots; the code appends the F_IDLE idle slots at either speed
// - Cell mask disables protection on non-cells
// - All inputs reported raw, the five cells also in millivolts
`ifndef MONITOR_REGS_SVH
`define MONITOR_REGS_SVH
`define A_CMD 8'h00
`define A_RESP 8'h04
`define A_STAT 8'h08
`define A_CFG 8'h0c
`define A_CAL 8'h10
`define CFG_RST 32'h0000_001f
`define CFG_ALL 32'h0000_ffff
`define CFG_LIVE 32'h0000_e3e0
`define CAL_RST 32'h0000_4000
`define F_FAST 5
`define F_IDLE 9:6
`define F_AUX 12:10
`define F_USER 15:13
`define F_GAIN 15:0
`define F_OFS 31:16
`define S_DENY 5
`define CMD_OP 6:0
`define CMD_ARG 31:16
`define DC_RESTART 7'h01
`define DC_CELL 7'h14
`define DC_SUB 7'h3e
`define DC_USER 7'h60
`define SC_SEAL 16'h0030
`define SC_IROM 16'h0010
`define SC_DROM 16'h0011
`define SC_CHK 16'h0012
`define SC_CIN 16'h0090
`define SC_COUT 16'h0092
`define SC_OTP 16'h00a0
`define SC_RAW_HI 12'h010
`define CH_TOP 4'h5
`define CH_TEMP 4'h8
`define CH_AUX 4'hb
`define CLK_NS 20
`define SLOT_NS 3000000
`define FAST_NS 1500000
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// ==== verilog/monitor_pkg.sv ====
// Purpose: Types shared by the monitor core.
// Assumes: Nothing beyond the header.
// Notes: Security level and signature engine use one-hot codes.
package monitor_pkg;
	typedef enum logic [2:0] {
		restricted_level   = 3'b001,
		intermediate_level = 3'b010,
		unrestricted_level = 3'b100
	} level_e;
	typedef enum logic [1:0] {
		sig_idle = 2'b01,
		sig_run  = 2'b10
	} sig_e;
	typedef enum logic [1:0] {
		normal_state           = 2'h0,
		sleep_state            = 2'h1,
		lowest_retention_state = 2'h2,
		shutdown_state         = 2'h3
	} power_e;
endpackage

// ==== verilog/monitor_config_access_and_scan.sv ====
// Purpose: Command decode, security, settings, scratchpad and measurement loop.
// Assumes: ROM answers one cycle after its address; ADC done comes within its slot.
// Notes: Key values below are arbitrary; ROM_WORDS must be at least 2.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_regs.svh"
module monitor_config_access_and_scan
	import monitor_pkg::*;
#(
	parameter int          SLOT_CYC  = `SLOT_NS / `CLK_NS, // Normal slot in cycles.
	parameter int          FAST_CYC  = `FAST_NS / `CLK_NS, // Fast slot in cycles.
	parameter int          ROM_WORDS = 256,                // Words per ROM.
	parameter logic [15:0] KEY_MID_A = 16'h1234,           // Arbitrary key.
	parameter logic [15:0] KEY_MID_B = 16'h5678,           // Arbitrary key.
	parameter logic [15:0] KEY_TOP_A = 16'h9abc,           // Arbitrary key.
	parameter logic [15:0] KEY_TOP_B = 16'hdef0            // Arbitrary key.
)(
	input  wire logic                         aclk,         // Clock.
	input  wire logic                         aresetn,      // Sync reset, low.
	input  wire logic [7:0]                   awaddr,       // Write address.
	input  wire logic                         awvalid,      // Write address valid.
	output var  logic                         awready,      // Write address ready.
	input  wire logic [31:0]                  wdata,        // Write data.
	input  wire logic [3:0]                   wstrb,        // Byte enables.
	input  wire logic                         wvalid,       // Write data valid.
	output var  logic                         wready,       // Write data ready.
	output var  logic [1:0]                   bresp,        // Write response.
	output var  logic                         bvalid,       // Write response valid.
	input  wire logic                         bready,       // Write response ready.
	input  wire logic [7:0]                   araddr,       // Read address.
	input  wire logic                         arvalid,      // Read address valid.
	output var  logic                         arready,      // Read address ready.
	output var  logic [31:0]                  rdata,        // Read data.
	output var  logic [1:0]                   rresp,        // Read response.
	output var  logic                         rvalid,       // Read data valid.
	input  wire logic                         rready,       // Read data ready.
	input  wire power_e                       power_state,  // Power state.
	output var  logic                         adc_start,    // Conversion start pulse.
	output var  logic [3:0]                   adc_chan,     // Multiplexer channel.
	input  wire logic                         adc_done,     // Conversion done pulse.
	input  wire logic [23:0]                  adc_raw,      // Raw signed result.
	output var  logic                         rom_sel,      // 0 instruction, 1 data.
	output var  logic [$clog2(ROM_WORDS)-1:0] rom_addr,     // ROM word address.
	input  wire logic [31:0]                  rom_data,     // ROM word.
	output var  logic [4:0]                   cell_prot_en, // Cell protection enables.
	output var  logic                         halted        // Rewrite state.
);
	localparam int          RW     = $clog2(ROM_WORDS);
	localparam logic [17:0] SLOT_L = 18'(SLOT_CYC - 1);
	localparam logic [17:0] FAST_L = 18'(FAST_CYC - 1);

	logic [7:0]  aw_a;
	logic        aw_h;
	logic        w_h;
	logic [31:0] w_d;
	logic [3:0]  w_s;
	logic        wr_go;
	logic        wr_err;
	logic [7:0]  wa;
	logic [7:0]  ra;
	logic [31:0] wm;
	logic [31:0] cm;
	logic [31:0] rd_v;
	logic        rd_e;
	level_e      level;
	logic        lv_mid;
	logic        lv_top;
	logic        kp_mid;
	logic        kp_top;
	logic        mism;
	logic        denied;
	logic        deny;
	logic        boot;
	logic        otp_prog;
	logic [31:0] cfg;
	logic [31:0] cal;
	logic [31:0] resp;
	logic [31:0] last_cmd;
	logic [31:0] otp_cfg;
	logic [31:0] otp_cal;
	logic [31:0] otp_sig;
	logic [31:0] stat_sig;
	logic [31:0] scr [8];
	logic [31:0] otp_scr [8];
	logic [31:0] rawv [16];
	logic [15:0] mv [5];
	logic        cmd_go;
	logic        sub_go;
	logic [6:0]  op;
	logic [6:0]  cidx;
	logic [15:0] arg;
	logic        k_ma;
	logic        k_mb;
	logic        k_ta;
	logic        k_tb;
	logic        s_seal;
	logic        s_irom;
	logic        s_drom;
	logic        s_chk;
	logic        s_cin;
	logic        s_cout;
	logic        s_otp;
	logic        s_raw;
	logic        cfg_we;
	logic        cal_we;
	logic        scr_we;
	logic        scr_w;
	logic        volt_w;
	logic        scr_r;
	logic        volt_r;
	sig_e        sig_st;
	logic [RW:0] sig_n;
	logic        sig_rv;
	logic        sig_done;
	logic [31:0] acc;
	logic [31:0] fold;
	logic        run_ok;
	logic        restart;
	logic [4:0]  sl;
	logic [4:0]  kd;
	logic [17:0] tmr;
	logic [1:0]  li;
	logic [2:0]  aux3;
	logic [3:0]  loop_len;
	logic [4:0]  total;
	logic [3:0]  ksum;
	logic [3:0]  aux_i;
	logic [3:0]  ch;
	logic signed [40:0] prod;
	logic signed [26:0] sum;
	logic [15:0] mvc;

	// Write decode, permissions and command fields.
	assign wr_go  = aw_h & w_h & ~bvalid;
	assign wa     = {aw_a[7:2], 2'b00};
	assign ra     = {araddr[7:2], 2'b00};
	assign wm     = {{8{w_s[3]}}, {8{w_s[2]}}, {8{w_s[1]}}, {8{w_s[0]}}};
	assign scr_w  = wa[7:5] == 3'h2;
	assign volt_w = wa[7:5] == 3'h1 && wa[4:2] < 3'h5;
	assign scr_r  = ra[7:5] == 3'h2;
	assign volt_r = ra[7:5] == 3'h1 && ra[4:2] < 3'h5;
	assign wr_err = !(wa == `A_CMD || wa == `A_RESP || wa == `A_STAT || wa == `A_CFG
		|| wa == `A_CAL || volt_w || scr_w);
	assign lv_mid = level != restricted_level;
	assign lv_top = level == unrestricted_level;
	assign cmd_go = wr_go && wa == `A_CMD;
	assign op     = w_d[`CMD_OP];
	assign arg    = w_d[`CMD_ARG];
	assign cidx   = op - `DC_CELL;
	assign sub_go = cmd_go && op == `DC_SUB;
	assign restart = cmd_go && op == `DC_RESTART;
	assign k_ma   = sub_go && arg == KEY_MID_A;
	assign k_mb   = sub_go && arg == KEY_MID_B;
	assign k_ta   = sub_go && arg == KEY_TOP_A;
	assign k_tb   = sub_go && arg == KEY_TOP_B;
	assign s_seal = sub_go && arg == `SC_SEAL;
	assign s_irom = sub_go && arg == `SC_IROM;
	assign s_drom = sub_go && arg == `SC_DROM;
	assign s_chk  = sub_go && arg == `SC_CHK;
	assign s_cin  = sub_go && arg == `SC_CIN;
	assign s_cout = sub_go && arg == `SC_COUT;
	assign s_otp  = sub_go && arg == `SC_OTP;
	assign s_raw  = sub_go && arg[15:4] == `SC_RAW_HI;
	assign deny = (wr_go && wa == `A_CFG && !lv_mid)
		|| (wr_go && wa == `A_CAL && !halted)
		|| (wr_go && scr_w && !lv_top)
		|| (k_ma && level != restricted_level)
		|| (k_mb && !(kp_mid && level == restricted_level))
		|| (k_ta && level != intermediate_level)
		|| (k_tb && !(kp_top && level == intermediate_level))
		|| ((s_irom || s_drom) && (!lv_mid || sig_st != sig_idle))
		|| (s_chk && !lv_mid)
		|| (s_cin && !lv_top)
		|| (s_cout && !halted)
		|| (s_otp && (!lv_top || otp_prog));
	assign cfg_we = wr_go && wa == `A_CFG && lv_mid;
	assign cal_we = wr_go && wa == `A_CAL && halted;
	assign scr_we = wr_go && scr_w && lv_top;
	assign cm = (halted ? wm : wm & `CFG_LIVE) & `CFG_ALL;

	// Write channel: address and data accepted in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
			aw_h    <= 1'b0;
			w_h     <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `RESP_OK;
		end else begin
			awready <= !aw_h && !(awvalid && awready);
			wready  <= !w_h && !(wvalid && wready);
			if (awvalid && awready) begin
				aw_h <= 1'b1;
				aw_a <= awaddr;
			end
			if (wvalid && wready) begin
				w_h <= 1'b1;
				w_d <= wdata;
				w_s <= wstrb;
			end
			if (wr_go) begin
				aw_h   <= 1'b0;
				w_h    <= 1'b0;
				bvalid <= 1'b1;
				bresp  <= wr_err ? `RESP_ERR : `RESP_OK;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_v = 32'h0000_0000;
		rd_e = 1'b0;
		if (ra == `A_CMD) rd_v = last_cmd;
		else if (ra == `A_RESP) rd_v = resp;
		else if (ra == `A_STAT) rd_v = {24'h00_0000, otp_prog, sig_st == sig_run, denied, mism,
			halted, level};
		else if (ra == `A_CFG) rd_v = cfg;
		else if (ra == `A_CAL) rd_v = cal;
		else if (volt_r) rd_v = {{16{mv[ra[4:2]][15]}}, mv[ra[4:2]]};
		else if (scr_r) rd_v = scr[ra[4:2]];
		else rd_e = 1'b1;
	end

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `RESP_OK;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= rd_v;
			rresp   <= rd_e ? `RESP_ERR : `RESP_OK;
		end else if (rvalid) begin
			if (rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end else begin
			arready <= 1'b1;
		end
	end

	always_comb begin
		stat_sig = cfg;
		for (int i = 0; i < 8; i++) stat_sig = {stat_sig[30:0], stat_sig[31]} ^ scr[i];
	end

	// Working settings and scratchpad, kept in every state but shutdown; stored copy, kept in all states.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg      <= `CFG_RST;
			cal      <= `CAL_RST;
			boot     <= 1'b1;
			otp_prog <= 1'b0;
			otp_cfg  <= 32'h0000_0000;
			otp_cal  <= 32'h0000_0000;
			otp_sig  <= 32'h0000_0000;
			for (int i = 0; i < 8; i++) begin
				scr[i]     <= 32'h0000_0000;
				otp_scr[i] <= 32'h0000_0000;
			end
		end else if (power_state == shutdown_state) begin
			cfg  <= `CFG_RST;
			cal  <= `CAL_RST;
			boot <= 1'b1;
			for (int i = 0; i < 8; i++) scr[i] <= 32'h0000_0000;
		end else if (boot) begin
			boot <= 1'b0;
			cfg  <= otp_prog ? otp_cfg : `CFG_RST;
			cal  <= otp_prog ? otp_cal : `CAL_RST;
			for (int i = 0; i < 8; i++) scr[i] <= otp_prog ? otp_scr[i] : 32'h0000_0000;
		end else begin
			if (cfg_we) cfg <= (cfg & ~cm) | (w_d & cm);
			if (cmd_go && op == `DC_USER) cfg[`F_USER] <= arg[2:0];
			if (cal_we) cal <= (cal & ~wm) | (w_d & wm);
			if (scr_we) scr[wa[4:2]] <= (scr[wa[4:2]] & ~wm) | (w_d & wm);
			if (s_otp && !deny) begin
				otp_prog <= 1'b1;
				otp_cfg  <= cfg;
				otp_cal  <= cal;
				otp_sig  <= stat_sig;
				for (int i = 0; i < 8; i++) otp_scr[i] <= scr[i];
			end
		end
	end

	// Security level, pending first keys and rewrite state.
	always_ff @(posedge aclk) begin
		if (!aresetn || power_state == shutdown_state) begin
			level  <= restricted_level;
			kp_mid <= 1'b0;
			kp_top <= 1'b0;
			halted <= 1'b0;
		end else begin
			if (sub_go) begin
				kp_mid <= k_ma && !deny;
				kp_top <= k_ta && !deny;
			end
			if (k_mb && !deny) level <= intermediate_level;
			if (k_tb && !deny) level <= unrestricted_level;
			if (s_seal) level <= restricted_level;
			if (s_cin && !deny) halted <= 1'b1;
			if ((s_cout && !deny) || s_seal) halted <= 1'b0;
		end
	end

	// Flags and response word.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			denied   <= 1'b0;
			mism     <= 1'b0;
			resp     <= 32'h0000_0000;
			last_cmd <= 32'h0000_0000;
		end else begin
			if (cmd_go) last_cmd <= w_d;
			if (deny) denied <= 1'b1;
			else if (wr_go && wa == `A_STAT && w_d[`S_DENY] && wm[`S_DENY]) denied <= 1'b0;
			if (s_chk && !deny) begin
				mism <= stat_sig != otp_sig;
				resp <= stat_sig;
			end
			if (cmd_go && cidx < 7'h05) resp <= {{16{mv[cidx[2:0]][15]}}, mv[cidx[2:0]]};
			if (s_raw) resp <= rawv[arg[3:0]];
			if (sig_done) resp <= fold;
		end
	end

	// ROM signature engine.
	assign fold     = {acc[30:0], acc[31]} ^ rom_data;
	assign sig_done = sig_st == sig_run && sig_rv && sig_n == (RW + 1)'(ROM_WORDS - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn || power_state == shutdown_state) begin
			sig_st   <= sig_idle;
			rom_sel  <= 1'b0;
			rom_addr <= '0;
			sig_n    <= '0;
			sig_rv   <= 1'b0;
			acc      <= 32'h0000_0000;
		end else begin
			case (sig_st)
				sig_idle: begin
					if ((s_irom || s_drom) && !deny) begin
						sig_st   <= sig_run;
						rom_sel  <= s_drom;
						rom_addr <= '0;
						sig_n    <= '0;
						sig_rv   <= 1'b0;
						acc      <= 32'h0000_0000;
					end
				end
				sig_run: begin
					sig_rv <= 1'b1;
					if (rom_addr != RW'(ROM_WORDS - 1)) rom_addr <= rom_addr + 1'b1;
					if (sig_rv) begin
						acc   <= fold;
						sig_n <= sig_n + 1'b1;
					end
					if (sig_done) begin
						sig_st <= sig_idle;
						sig_rv <= 1'b0;
					end
				end
				default: sig_st <= sig_idle;
			endcase
		end
	end

	// Slot plan of the measurement loop.
	assign run_ok   = power_state == normal_state && !halted && !boot;
	assign aux3     = cfg[`F_AUX] > 3'h3 ? 3'h3 : cfg[`F_AUX];
	assign loop_len = 4'h7 + {1'b0, aux3};
	assign total    = {1'b0, loop_len} + {1'b0, cfg[`F_IDLE]};
	assign kd       = sl - 5'h07;
	assign ksum     = kd[3:0] + {2'b00, li} + {1'b0, li, 1'b0};
	always_comb begin
		aux_i = kd[3:0];
		if (cfg[`F_AUX] > 3'h3) aux_i = ksum % {1'b0, cfg[`F_AUX]};
		if (sl < 5'h05) ch = sl[3:0];
		else if (sl == 5'h05) ch = `CH_TOP + {2'b00, li};
		else if (sl == 5'h06) ch = `CH_TEMP + {2'b00, li};
		else ch = `CH_AUX + aux_i;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run_ok || restart) begin
			sl        <= 5'h00;
			tmr       <= 18'h0_0000;
			li        <= 2'h0;
			adc_start <= 1'b0;
			adc_chan  <= 4'h0;
		end else begin
			adc_start <= 1'b0;
			if (tmr == 18'h0_0000) begin
				tmr <= cfg[`F_FAST] ? FAST_L : SLOT_L;
				sl  <= (sl == total - 5'h01) ? 5'h00 : sl + 5'h01;
				if (sl == total - 5'h01) li <= (li == 2'h2) ? 2'h0 : li + 2'h1;
				if (sl < {1'b0, loop_len}) begin
					adc_start <= 1'b1;
					adc_chan  <= ch;
				end
			end else begin
				tmr <= tmr - 18'h0_0001;
			end
		end
	end

	// Result correction and capture.
	assign prod = $signed(adc_raw) * $signed({1'b0, cal[`F_GAIN]});
	assign sum  = prod[40:14] + {{11{cal[31]}}, cal[`F_OFS]};
	assign mvc  = (sum > 27'sd32767) ? 16'h7fff : (sum < -27'sd32768) ? 16'h8000 : sum[15:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 16; i++) rawv[i] <= 32'h0000_0000;
		end else if (adc_done) begin
			rawv[adc_chan] <= {{8{adc_raw[23]}}, adc_raw};
		end
	end

	for (genvar g = 0; g < 5; g++) begin : g_cell
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				mv[g]           <= 16'h0000;
				cell_prot_en[g] <= 1'b0;
			end else begin
				cell_prot_en[g] <= cfg[g] && !boot;
				if (adc_done && adc_chan == 4'(g)) mv[g] <= mvc;
			end
		end
	end
endmodule // monitor_config_access_and_scan
`default_nettype wire

// ==== test/monitor_chk.sv ====
// Purpose: Port assertions for the monitor core.
// Assumes: Sees only the top module's ports.
// Notes: Bound to the core at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module monitor_chk
	import monitor_pkg::*;
(
	input wire logic       aclk,        // Clock.
	input wire logic       aresetn,     // Sync reset, low.
	input wire logic       awvalid,     // Write address valid.
	input wire logic       awready,     // Write address ready.
	input wire logic       wvalid,      // Write data valid.
	input wire logic       wready,      // Write data ready.
	input wire logic       bvalid,      // Write response valid.
	input wire logic       bready,      // Write response ready.
	input wire logic       arvalid,     // Read address valid.
	input wire logic       arready,     // Read address ready.
	input wire logic       rvalid,      // Read data valid.
	input wire logic       rready,      // Read data ready.
	input wire power_e     power_state, // Power state.
	input wire logic       adc_start,   // Conversion start.
	input wire logic [3:0] adc_chan,    // Slot channel.
	input wire logic       halted       // Rewrite state.
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_answer_a: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write answer late");
	b_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	rd_answer_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	r_hold_a: assert property (rvalid && !rready |=> rvalid)
		else $error("read response dropped");
	ar_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answering");
	slot_hold_a: assert property (adc_start |=> (!adc_start
		&& ($stable(adc_chan) || halted || power_state != normal_state)) [*8])
		else $error("slot cut short");
	halt_quiet_a: assert property (halted |=> !adc_start)
		else $error("measurement while halted");
	power_quiet_a: assert property (power_state != normal_state |=> !adc_start)
		else $error("measurement outside normal state");
	shut_clear_a: assert property (power_state == shutdown_state |=> !halted)
		else $error("rewrite state kept in shutdown");
	cover property (adc_start && adc_chan == 4'h0);
	cover property (halted);
	cover property (bvalid && bready);
endmodule // monitor_chk
bind monitor_config_access_and_scan monitor_chk chk (.aclk, .aresetn, .awvalid, .awready,
	.wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .power_state,
	.adc_start, .adc_chan, .halted);
`default_nettype wire

// ==== test/afe_model.sv ====
// Purpose: Converter and ROM seen by the core.
// Assumes: A result comes four cycles after each start.
// Notes: Cell 2 reads negative to exercise sign extension.
`timescale 1ns/1ps
`default_nettype none
module afe_model (
	input  wire logic        aclk,      // Clock.
	input  wire logic        adc_start, // Conversion request.
	input  wire logic [3:0]  adc_chan,  // Channel to convert.
	output var  logic        adc_done,  // Result strobe.
	output var  logic [23:0] adc_raw,   // Raw result.
	input  wire logic        rom_sel,   // ROM choice.
	input  wire logic [1:0]  rom_addr,  // ROM word.
	output var  logic [31:0] rom_data   // ROM answer.
);
	logic [1:0]  busy_cnt = 2'h0;
	logic [23:0] result;
	assign result = (adc_chan == 4'h2) ? 24'hfffffb : 24'd3000 + {20'h0, adc_chan};
	always_ff @(posedge aclk) begin
		busy_cnt <= adc_start ? 2'h3 : busy_cnt - {1'b0, busy_cnt != 2'h0};
		adc_done <= busy_cnt == 2'h1;
		// Between results the lines toggle so a stale sample cannot pass.
		adc_raw <= (busy_cnt == 2'h1) ? result : ~adc_raw;
		rom_data <= {16'h0, rom_sel ? 8'h5a : 8'hc3, 6'h0, rom_addr} ^ 32'h1357_9bdf;
	end
endmodule // afe_model
`default_nettype wire

// ==== test/test_monitor_config_access_and_scan.sv ====
// Purpose: Self-checking bench for the monitor core.
// Assumes: Short slots of 20 and 10 cycles, four ROM words.
// Notes: Response ready lines rise only once an answer has been seen.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_regs.svh"
module test_monitor_config_access_and_scan
	import monitor_pkg::*;
;
	localparam logic [15:0] KMA = 16'h2a61, KMB = 16'h7c03; // Arbitrary keys.
	localparam logic [15:0] KTA = 16'h4e19, KTB = 16'hb5d2; // Arbitrary keys.
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rom_data, rv;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, halted, adc_start, adc_done, rom_sel;
	logic [1:0]  bresp, rresp, rr, br, rom_addr;
	logic [3:0]  adc_chan, wstrb = 4'hf;
	logic [23:0] adc_raw;
	logic [4:0]  cell_prot_en;
	power_e      power_state = normal_state;
	int          error_cnt = 0, checked = 0;
	monitor_config_access_and_scan #(.SLOT_CYC(20), .FAST_CYC(10), .ROM_WORDS(4),
		.KEY_MID_A(KMA), .KEY_MID_B(KMB), .KEY_TOP_A(KTA), .KEY_TOP_B(KTB)) uut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .power_state, .adc_start, .adc_chan, .adc_done, .adc_raw, .rom_sel,
		.rom_addr, .rom_data, .cell_prot_en, .halted);
	afe_model afe (.aclk, .adc_start, .adc_chan, .adc_done, .adc_raw, .rom_sel, .rom_addr,
		.rom_data);
	initial begin
		forever #10 aclk = ~aclk;
	end
	task automatic conclude;
		$display("checks %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t ns: %h, expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (awready && !aw) begin
				aw = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid)
			@(posedge aclk);
		bready <= 1'b1;
		@(posedge aclk);
		br = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		@(posedge aclk);
		while (!arready)
			@(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (!rvalid)
			@(posedge aclk);
		rready <= 1'b1;
		@(posedge aclk);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(rv, e);
	endtask
	task automatic sub(input logic [15:0] c);
		wr(`A_CMD, {c, 9'h0, `DC_SUB});
		rd(`A_STAT);
		while (rv[6])
			rd(`A_STAT);
	endtask
	task automatic meas(output int n, output int cyc, output logic [3:0] c5, output logic [3:0] c6);
		do @(posedge aclk); while (!(adc_start && adc_chan == 4'h0));
		n = 1;
		cyc = 0;
		forever begin
			@(posedge aclk);
			cyc++;
			if (adc_start) begin
				if (adc_chan == 4'h0)
					break;
				if (n < 5)
					chk({28'h0, adc_chan}, n);
				if (n == 5)
					c5 = adc_chan;
				if (n == 6)
					c6 = adc_chan;
				n++;
			end
		end
	endtask
	task automatic t_boot;
		rchk(`A_CFG, `CFG_RST);
		rchk(`A_CAL, `CAL_RST);
		rchk(`A_STAT, 32'h1);
		chk({27'h0, cell_prot_en}, 32'h1f);
		rd(8'h14);
		chk({30'h0, rr}, {30'h0, `RESP_ERR});
		wr(8'h14, 32'h0);
		chk({30'h0, br}, {30'h0, `RESP_ERR});
		$display("boot test done");
	endtask
	task automatic t_restricted_level;
		wr(`A_CFG, 32'h20);
		chk({30'h0, br}, {30'h0, `RESP_OK});
		rchk(`A_CFG, `CFG_RST);
		rchk(`A_STAT, 32'h21);
		wr(`A_STAT, 32'h20);
		wr(8'h40, 32'h1234_5678);
		rchk(8'h40, 32'h0);
		sub(KTA);
		sub(KTB);
		rd(`A_STAT);
		chk({29'h0, rv[2:0]}, 32'h1);
		wr(`A_CMD, {16'h5, 9'h0, `DC_USER});
		rchk(`A_CFG, 32'ha01f);
		$display("restricted test done");
	endtask
	task automatic t_levels;
		logic [31:0] sig;
		sub(KMA);
		sub(KMB);
		rd(`A_STAT);
		chk({29'h0, rv[2:0]}, 32'h2);
		wr(8'h40, 32'h1234_5678);
		rchk(8'h40, 32'h0);
		sub(`SC_IROM);
		rd(`A_RESP);
		sig = rv;
		sub(`SC_IROM);
		rchk(`A_RESP, sig);
		sub(`SC_DROM);
		rd(`A_RESP);
		chk({31'h0, rv != sig}, 32'h1);
		sub(KTA);
		sub(KTB);
		rd(`A_STAT);
		chk({29'h0, rv[2:0]}, 32'h4);
		wr(8'h44, 32'ha5a5_5a5a);
		rchk(8'h44, 32'ha5a5_5a5a);
		wstrb <= 4'h2;
		wr(8'h48, 32'hffff_ffff);
		wstrb <= 4'hf;
		rchk(8'h48, 32'h0000_ff00);
		$display("security test done");
	endtask
	task automatic t_rewrite;
		sub(`SC_CIN);
		chk({31'h0, halted}, 32'h1);
		wr(`A_CAL, 32'h000a_4000);
		wr(`A_CFG, 32'h3);
		rchk(`A_CFG, 32'h3);
		sub(`SC_COUT);
		chk({31'h0, halted}, 32'h0);
		chk({27'h0, cell_prot_en}, 32'h3);
		$display("rewrite test done");
	endtask
	task automatic t_loop;
		int n, cyc;
		logic [3:0] c5, c6;
		logic [15:0] m5, m6;
		for (int a = 0; a < 5; a++) begin
			sub(`SC_CIN);
			wr(`A_CFG, 32'h3f + 32'(a) * 32'h400);
			sub(`SC_COUT);
			meas(n, cyc, c5, c6);
			chk(n, 7 + (a > 3 ? 3 : a));
			chk(cyc, n * 10);
		end
		wr(`A_CFG, 32'h109f);
		m5 = 16'h0;
		m6 = 16'h0;
		for (int l = 0; l < 3; l++) begin
			meas(n, cyc, c5, c6);
			chk(cyc, 240);
			m5 = m5 | (16'h1 << c5);
			m6 = m6 | (16'h1 << c6);
		end
		chk({m6, m5}, 32'h0700_00e0);
		$display("loop test done");
	endtask
	task automatic t_values;
		logic [31:0] e;
		for (int c = 0; c < 5; c++) begin
			e = (c == 2) ? 32'hffff_fffb : 32'd3000 + 32'(c);
			rchk(8'(32 + 4 * c), e + 32'd10);
			wr(`A_CMD, 32'h14 + 32'(c));
			rchk(`A_RESP, e + 32'd10);
			sub({`SC_RAW_HI, 4'(c)});
			rchk(`A_RESP, e);
		end
		$display("result test done");
	endtask
	task automatic t_commit;
		logic [31:0] cfg;
		sub(`SC_OTP);
		rd(`A_STAT);
		chk({31'h0, rv[7]}, 32'h1);
		sub(`SC_CHK);
		rd(`A_STAT);
		chk({31'h0, rv[4]}, 32'h0);
		rd(`A_CFG);
		cfg = rv;
		wr(`A_CFG, cfg ^ 32'h20);
		sub(`SC_CHK);
		rd(`A_STAT);
		chk({31'h0, rv[4]}, 32'h1);
		power_state <= sleep_state;
		repeat (4) @(posedge aclk);
		rchk(`A_CFG, cfg ^ 32'h20);
		power_state <= shutdown_state;
		repeat (4) @(posedge aclk);
		power_state <= normal_state;
		repeat (2) @(posedge aclk);
		rchk(`A_CFG, cfg);
		rchk(8'h44, 32'ha5a5_5a5a);
		rd(`A_STAT);
		chk({29'h0, rv[2:0]}, 32'h1);
		$display("power test done");
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_boot;
		t_restricted_level;
		t_levels;
		t_rewrite;
		t_loop;
		t_values;
		t_commit;
		conclude;
	end
	// The whole run needs well under a third of this span.
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		conclude;
	end
endmodule // test_monitor_config_access_and_scan
`default_nettype wire
